// >>> core/usdb_top.sv
// serial transceiver data buffer path: shared data port, tx path, rx fifo
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module usdb_top (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // register port
  input wire logic [usdb_pkg::ADDR_W-1:0] ADDR,
  input wire logic [usdb_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [usdb_pkg::DATA_W-1:0] RDATA,
  // serial line
  input wire logic SERIAL_IN_PIN,
  output logic SERIAL_OUT_PIN,
  // interrupt
  output logic IRQ
);
  import usdb_pkg::*;
  usdb_fifo_if fif ();
  usdb_rx_fifo u_fifo (.clk(CLK_SYS), .rst(RST), .f(fif));

  ////////////////////////////////////////////////////////////////
  // registers and bus decode
  logic [7:0] ctrl, next_ctrl;
  logic [DIV_W-1:0] baud_divisor, next_div;
  logic [2:0] stat, next_stat, mask, next_mask;
  logic [7:0] rdata, next_rdata;
  logic [7:0] char_mask;
  logic tx_buffer_empty_flag, next_tbe;
  logic [7:0] transmit_holding_buffer, next_thb;
  logic wr_data, rd_data, load_shift, rx_done, ovr_event;
  logic [7:0] rx_char;

  // character length 5..8 from two size bits
  always_comb begin
    char_mask = 8'hFF >> (2'h3 - ctrl[CTRL_SIZE_LO +: 2]);
  end

  always_comb begin
    wr_data = WR && (ADDR == OFS_DATA);
    rd_data = RD && (ADDR == OFS_DATA);
    next_ctrl = ctrl;
    next_div = baud_divisor;
    next_mask = mask;
    if (WR) begin
      if (ADDR == OFS_CTRL) begin
        next_ctrl = WDATA;
      end else if (ADDR == OFS_DIV) begin
        next_div = {baud_divisor[11:8], WDATA};
      end else if (ADDR == OFS_DIV + 4'h5) begin
        next_div = {WDATA[3:0], baud_divisor[7:0]};
      end else if (ADDR == OFS_MASK) begin
        next_mask = WDATA[2:0];
      end
    end
    next_rdata = 8'h00;
    if (RD) begin
      if (ADDR == OFS_DATA) begin
        next_rdata = fif.rdata & char_mask;
      end else if (ADDR == OFS_CTRL) begin
        next_rdata = ctrl;
      end else if (ADDR == OFS_DIV) begin
        next_rdata = baud_divisor[7:0];
      end else if (ADDR == OFS_DIV + 4'h5) begin
        next_rdata = {4'h0, baud_divisor[11:8]};
      end else if (ADDR == OFS_STAT) begin
        next_rdata = {4'h0, tx_buffer_empty_flag, stat};
      end else if (ADDR == OFS_MASK) begin
        next_rdata = {5'h00, mask};
      end
    end
    // tx holding buffer
    next_tbe = tx_buffer_empty_flag;
    next_thb = transmit_holding_buffer;
    if (load_shift) begin
      next_tbe = 1'b1;
    end
    if (wr_data && tx_buffer_empty_flag) begin
      next_thb = WDATA & char_mask;
      next_tbe = 1'b0;
    end
    // sticky events, read of status clears, set wins
    next_stat = stat;
    if (RD && (ADDR == OFS_STAT)) begin
      next_stat = 3'h0;
    end
    if (load_shift) begin
      next_stat[EV_TXE] = 1'b1;
    end
    if (rx_done) begin
      next_stat[EV_RXC] = 1'b1;
    end
    if (ovr_event) begin
      next_stat[EV_OVR] = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ctrl <= CTRL_RESET;
      baud_divisor <= DIV_RESET;
      mask <= MASK_RESET;
      stat <= 3'h0;
      rdata <= 8'h00;
      tx_buffer_empty_flag <= 1'b1;
      transmit_holding_buffer <= 8'h00;
    end else begin
      ctrl <= next_ctrl;
      baud_divisor <= next_div;
      mask <= next_mask;
      stat <= next_stat;
      rdata <= next_rdata;
      tx_buffer_empty_flag <= next_tbe;
      transmit_holding_buffer <= next_thb;
    end
  end

  assign RDATA = rdata;
  assign IRQ = |(stat & mask);

  ////////////////////////////////////////////////////////////////
  // baud tick: one tick per divisor+1 clocks, then 16 or 8 per bit
  logic [DIV_W-1:0] bcnt, next_bcnt;
  logic tick;
  logic [4:0] ovs;
  always_comb begin
    tick = (bcnt == DIV_RESET);
    // reload at once when the divisor drops below the running count
    next_bcnt = (tick || bcnt > baud_divisor) ? baud_divisor : bcnt - 12'h001;
    ovs = ctrl[CTRL_DBL] ? OVS_DOUBLE : OVS_NORMAL;
  end
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      bcnt <= DIV_RESET;
    end else begin
      bcnt <= next_bcnt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // transmitter
  usdb_tx_state_t tst, next_tst;
  logic [7:0] tsh, next_tsh;
  logic [4:0] tph, next_tph;
  logic [2:0] tbit, next_tbit;
  logic tout, next_tout;
  always_comb begin
    next_tst = tst;
    next_tsh = tsh;
    next_tph = tph;
    next_tbit = tbit;
    next_tout = tout;
    load_shift = 1'b0;
    if (tick && tst != TX_IDLE) begin
      next_tph = tph + 5'h01;
    end
    case (tst)
      TX_IDLE: begin
        next_tout = 1'b1;
        if (ctrl[CTRL_TXEN] && !tx_buffer_empty_flag) begin
          load_shift = 1'b1;
          next_tsh = transmit_holding_buffer;
          next_tst = TX_START;
          next_tph = 5'h00;
          next_tout = 1'b0;
        end
      end
      TX_START: begin
        if (tick && tph == ovs - 5'h01) begin
          next_tph = 5'h00;
          next_tout = tsh[0];
          next_tbit = 3'h0;
          next_tst = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tick && tph == ovs - 5'h01) begin
          next_tph = 5'h00;
          next_tsh = {1'b0, tsh[7:1]};
          if (tbit == 3'h4 + {1'b0, ctrl[CTRL_SIZE_LO +: 2]}) begin
            next_tout = 1'b1;
            next_tst = TX_STOP;
          end else begin
            next_tbit = tbit + 3'h1;
            next_tout = tsh[1];
          end
        end
      end
      TX_STOP: begin
        if (tick && tph == ovs - 5'h01) begin
          next_tst = TX_IDLE;
        end
      end
      default: next_tst = TX_IDLE;
    endcase
  end
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      tst <= TX_IDLE;
      tsh <= 8'h00;
      tph <= 5'h00;
      tbit <= 3'h0;
      tout <= 1'b1;
    end else begin
      tst <= next_tst;
      tsh <= next_tsh;
      tph <= next_tph;
      tbit <= next_tbit;
      tout <= next_tout;
    end
  end
  assign SERIAL_OUT_PIN = tout;

  ////////////////////////////////////////////////////////////////
  // receiver with waiting shift register and overrun
  logic sin_s1, sin_s2;
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sin_s1 <= 1'b1;
      sin_s2 <= 1'b1;
    end else begin
      sin_s1 <= SERIAL_IN_PIN;
      sin_s2 <= sin_s1;
    end
  end
  usdb_rx_state_t rst_q, next_rst_q;
  logic [7:0] rsh, next_rsh;
  logic [4:0] rph, next_rph;
  logic [2:0] rbit, next_rbit;
  logic wait_full, next_wait, drain;
  logic [7:0] wait_char, next_wchar;
  always_comb begin
    next_rst_q = rst_q;
    next_rsh = rsh;
    next_rph = rph;
    next_rbit = rbit;
    next_wait = wait_full;
    next_wchar = wait_char;
    rx_done = 1'b0;
    ovr_event = 1'b0;
    rx_char = 8'h00;
    if (tick && rst_q != RX_IDLE) begin
      next_rph = rph + 5'h01;
    end
    // waiting character drains when fifo has room
    drain = wait_full && (fif.count != 2'h2 || rd_data);
    if (drain) begin
      next_wait = 1'b0;
    end
    case (rst_q)
      RX_IDLE: begin
        if (ctrl[CTRL_RXEN] && !sin_s2) begin
          next_rst_q = RX_START;
          next_rph = 5'h00;
          ovr_event = wait_full && fif.count == 2'h2 && !rd_data;
        end
      end
      RX_START: begin
        if (tick && tph_half(rph, ovs)) begin
          next_rph = 5'h00;
          next_rbit = 3'h0;
          next_rst_q = sin_s2 ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (tick && rph == ovs - 5'h01) begin
          next_rph = 5'h00;
          next_rsh = {sin_s2, rsh[7:1]};
          if (rbit == 3'h4 + {1'b0, ctrl[CTRL_SIZE_LO +: 2]}) begin
            next_rst_q = RX_STOP;
          end else begin
            next_rbit = rbit + 3'h1;
          end
        end
      end
      RX_STOP: begin
        if (tick && rph == ovs - 5'h01) begin
          next_rst_q = RX_IDLE;
          rx_done = 1'b1;
          rx_char = (rsh >> (2'h3 - ctrl[CTRL_SIZE_LO +: 2])) & char_mask;
          if (wait_full || (fif.count == 2'h2 && !rd_data)) begin
            next_wait = 1'b1;
            next_wchar = rx_char;
          end
        end
      end
      default: next_rst_q = RX_IDLE;
    endcase
  end
  function automatic logic tph_half(input logic [4:0] p, input logic [4:0] o);
    tph_half = (p == (o >> 1) - 5'h01);
  endfunction
  // fifo gets the waiting character first, else a fresh one
  always_comb begin
    fif.pop = rd_data;
    fif.push = drain || (rx_done && !next_wait);
    fif.wdata = wait_full ? wait_char : rx_char;
  end
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rst_q <= RX_IDLE;
      rsh <= 8'h00;
      rph <= 5'h00;
      rbit <= 3'h0;
      wait_full <= 1'b0;
      wait_char <= 8'h00;
    end else begin
      rst_q <= next_rst_q;
      rsh <= next_rsh;
      rph <= next_rph;
      rbit <= next_rbit;
      wait_full <= next_wait;
      wait_char <= next_wchar;
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  a_drop_full: assert property (@(posedge CLK_SYS) disable iff (RST)
    (wr_data && !tx_buffer_empty_flag) |=> $stable(transmit_holding_buffer))
    else $error("write accepted while buffer full");
  a_accept_clr: assert property (@(posedge CLK_SYS) disable iff (RST)
    (wr_data && tx_buffer_empty_flag) |=> !tx_buffer_empty_flag)
    else $error("empty flag not cleared");
  a_tx_load: assert property (@(posedge CLK_SYS) disable iff (RST)
    (tst == TX_IDLE && ctrl[CTRL_TXEN] && !tx_buffer_empty_flag)
    |=> tx_buffer_empty_flag && tst == TX_START && !SERIAL_OUT_PIN)
    else $error("buffer not moved to shifter");
  a_read_pops: assert property (@(posedge CLK_SYS) disable iff (RST)
    (rd_data && fif.count == 2'h2 && !fif.push) |=> fif.count == 2'h1)
    else $error("read did not pop fifo");
  a_read_data: assert property (@(posedge CLK_SYS) disable iff (RST)
    rd_data |=> RDATA == ($past(fif.rdata) & $past(char_mask)))
    else $error("data read mismatch");
  a_fast_tick: assert property (@(posedge CLK_SYS) disable iff (RST)
    (baud_divisor == DIV_RESET && $past(baud_divisor) == DIV_RESET) |-> tick)
    else $error("zero divisor not fastest");
  a_ovs_sel: assert property (@(posedge CLK_SYS) disable iff (RST)
    ovs == (ctrl[CTRL_DBL] ? 5'h08 : 5'h10))
    else $error("oversample ratio wrong");
  a_overrun: assert property (@(posedge CLK_SYS) disable iff (RST)
    ovr_event |=> stat[EV_OVR])
    else $error("overrun not flagged");
  a_short_tx: assert property (@(posedge CLK_SYS) disable iff (RST)
    (wr_data && tx_buffer_empty_flag) |=> (transmit_holding_buffer & ~$past(char_mask)) == 8'h00)
    else $error("upper bits kept");
  c_tx_frame: cover property (@(posedge CLK_SYS) tst == TX_STOP ##1 tst == TX_IDLE);
  c_rx_done: cover property (@(posedge CLK_SYS) rx_done);
  c_overrun: cover property (@(posedge CLK_SYS) ovr_event);
  c_irq: cover property (@(posedge CLK_SYS) IRQ);
endmodule
`default_nettype wire

// >>> core/usdb_pkg.sv
// shared constants and types for the serial data buffer path
package usdb_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam int DIV_W = 12;
  localparam int FIFO_DEPTH = 2;
  // register offsets
  localparam logic [3:0] OFS_DATA = 4'h0;
  localparam logic [3:0] OFS_CTRL = 4'h1;
  localparam logic [3:0] OFS_DIV = 4'h2;
  localparam logic [3:0] OFS_STAT = 4'h3;
  localparam logic [3:0] OFS_MASK = 4'h4;
  // control fields
  localparam int CTRL_TXEN = 0;
  localparam int CTRL_RXEN = 1;
  localparam int CTRL_DBL = 2;
  localparam int CTRL_SIZE_LO = 3;
  localparam logic [7:0] CTRL_RESET = 8'h18;
  // status / event bits
  localparam int EV_TXE = 0;
  localparam int EV_RXC = 1;
  localparam int EV_OVR = 2;
  localparam int EV_W = 3;
  localparam logic [2:0] MASK_RESET = 3'h0;
  // oversampling per bit
  localparam logic [4:0] OVS_NORMAL = 5'h10;
  localparam logic [4:0] OVS_DOUBLE = 5'h08;
  localparam logic [DIV_W-1:0] DIV_RESET = 12'h000;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_START = 2'b01,
    TX_DATA = 2'b10,
    TX_STOP = 2'b11
  } usdb_tx_state_t;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } usdb_rx_state_t;
endpackage

// >>> core/usdb_fifo_if.sv
// link between the core and the receive fifo
`timescale 1ns/1ps
`default_nettype none
interface usdb_fifo_if;
  logic push;
  logic pop;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [1:0] count;
  modport core (output push, output pop, output wdata, input rdata, input count);
  modport store (input push, input pop, input wdata, output rdata, output count);
endinterface
`default_nettype wire

// >>> core/usdb_rx_fifo.sv
// two-level receive fifo with registered head output
`timescale 1ns/1ps
`default_nettype none
module usdb_rx_fifo (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fifo port
  usdb_fifo_if.store f
);
  import usdb_pkg::*;
  logic [7:0] mem [FIFO_DEPTH];
  logic [1:0] cnt;
  logic [7:0] head;
  logic [1:0] next_cnt;
  logic [7:0] next_m0, next_m1, next_head;
  logic do_push, do_pop;

  always_comb begin
    do_pop = f.pop && (cnt != 2'h0);
    do_push = f.push && ((cnt != 2'h2) || do_pop);
    next_m0 = mem[0];
    next_m1 = mem[1];
    next_cnt = cnt;
    if (do_pop) begin
      next_m0 = mem[1];
      next_cnt = cnt - 2'h1;
    end
    if (do_push) begin
      if (next_cnt == 2'h0) begin
        next_m0 = f.wdata;
      end else begin
        next_m1 = f.wdata;
      end
      next_cnt = next_cnt + 2'h1;
    end
    next_head = (next_cnt == 2'h0) ? 8'h00 : next_m0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem[0] <= 8'h00;
      mem[1] <= 8'h00;
      cnt <= 2'h0;
      head <= 8'h00;
    end else begin
      mem[0] <= next_m0;
      mem[1] <= next_m1;
      cnt <= next_cnt;
      head <= next_head;
    end
  end

  assign f.rdata = head;
  assign f.count = cnt;

  a_fifo_bound: assert property (@(posedge clk) disable iff (rst)
    cnt <= 2'h2) else $error("fifo count above two");
endmodule
`default_nettype wire

// >>> bench/usdb_line_model.sv
// line-side partner: sends frames to the block and captures frames from it
`timescale 1ns/1ps
`default_nettype none
module usdb_line_model (
  // clock
  input wire logic clk,
  // serial line
  input wire logic from_dut,
  output logic to_dut,
  // frame shape
  input wire logic [4:0] bit_clks,
  input wire logic [3:0] nbits
);
  logic [7:0] got[$];
  logic [7:0] v;
  int frame_errs = 0;

  initial to_dut = 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  // capture: sample mid-bit, lsb first, stop must be high
  always begin
    @(negedge from_dut);
    repeat (bit_clks / 2) @(posedge clk);
    v = 8'h00;
    for (int i = 0; i < nbits; i++) begin
      repeat (bit_clks) @(posedge clk);
      v[i] = from_dut;
    end
    repeat (bit_clks) @(posedge clk);
    if (from_dut !== 1'b1) frame_errs++;
    got.push_back(v);
  end

  //////////////////////////////////////////////////////////////////////////////
  // send one frame of nbits data bits; line idles high after the stop bit
  task automatic send(input logic [7:0] d);
    to_dut <= 1'b0;
    repeat (bit_clks) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      to_dut <= d[i];
      repeat (bit_clks) @(posedge clk);
    end
    to_dut <= 1'b1;
    repeat (bit_clks) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// >>> bench/usdb_top_test.sv
// self-checking bench for the serial data buffer path
`timescale 1ns/1ps
`default_nettype none
module usdb_top_test;
  import usdb_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [DATA_W-1:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic ser_in;
  logic ser_out;
  logic irq;
  logic [4:0] bit_clks;
  logic [3:0] nbits;
  logic [7:0] m;
  logic [7:0] wd;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;

  always #12.5 clk_sys = ~clk_sys;

  usdb_top dut (.CLK_SYS(clk_sys), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_stb),
    .RD(rd_stb), .RDATA(rdata), .SERIAL_IN_PIN(ser_in), .SERIAL_OUT_PIN(ser_out), .IRQ(irq));

  usdb_line_model line (.clk(clk_sys), .from_dut(ser_out), .to_dut(ser_in),
    .bit_clks(bit_clks), .nbits(nbits));

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic close_out;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1 check(rdata, exp);
  endtask

  task automatic irq_is(input logic e);
    #1 check({7'h00, irq}, {7'h00, e});
  endtask

  // wait, bounded, for the next frame seen on the line
  task automatic expect_tx(input logic [7:0] exp);
    for (int i = 0; i < 4000 && line.got.size() == 0; i++) @(posedge clk_sys);
    if (line.got.size() == 0) begin
      check(~exp, exp);
    end else begin
      check(line.got.pop_front(), exp);
    end
  endtask

  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      $display("Error at %0t ns: timeout", $time);
      failures++;
      close_out();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    bit_clks <= 5'h10;
    nbits <= 4'h8;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    #1 check({6'h00, ser_out, irq}, 8'h02);
    reg_rd(OFS_STAT, 8'h08);
    reg_rd(4'hF, 8'h00);
    // divisor halves read back, then back to zero for the fastest rate
    reg_wr(OFS_DIV, 8'h5A);
    reg_wr(4'h7, 8'hA3);
    reg_rd(OFS_DIV, 8'h5A);
    reg_rd(4'h7, 8'h03);
    reg_wr(4'h7, 8'h00);
    reg_wr(OFS_DIV, 8'h00);
    reg_rd(OFS_DIV, 8'h00);
    // transmitter off: first write held in buffer, second dropped
    reg_wr(OFS_CTRL, 8'h1A);
    reg_wr(OFS_DATA, 8'h11);
    reg_rd(OFS_STAT, 8'h00);
    reg_wr(OFS_DATA, 8'h22);
    reg_wr(OFS_CTRL, 8'h1B);
    expect_tx(8'h11);
    reg_rd(OFS_STAT, 8'h09);
    // buffer refilled while shifter busy, then a write to a full buffer
    reg_wr(OFS_DATA, 8'h33);
    repeat (20) @(posedge clk_sys);
    reg_wr(OFS_DATA, 8'h44);
    reg_wr(OFS_DATA, 8'h55);
    expect_tx(8'h33);
    expect_tx(8'h44);
    repeat (300) @(posedge clk_sys);
    check(8'(line.got.size()), 8'h00);
    // every size, 5 and 7 bits at normal speed, 6 and 8 bits at double speed, divisor zero
    for (int c = 0; c < 4; c++) begin
      nbits <= 4'(c + 5);
      bit_clks <= c[0] ? 5'h08 : 5'h10;
      m = 8'hFF >> (3 - c);
      wd = (8'hFF << (c + 5)) | (8'h15 & m);
      reg_wr(OFS_CTRL, {3'h0, 2'(c), c[0], 2'h3});
      reg_wr(OFS_DATA, wd);
      expect_tx(wd & m);
      line.send(8'hFF);
      repeat (4) @(posedge clk_sys);
      reg_rd(OFS_DATA, m);
    end
    // receive fifo fill, overrun and interrupt mask
    nbits <= 4'h8;
    bit_clks <= 5'h10;
    reg_wr(OFS_CTRL, 8'h1B);
    reg_rd(OFS_STAT, 8'h0B);
    reg_wr(OFS_MASK, 8'h04);
    line.send(8'h31);
    repeat (4) @(posedge clk_sys);
    irq_is(1'b0);
    line.send(8'h32);
    line.send(8'h33);
    line.send(8'h34);
    repeat (4) @(posedge clk_sys);
    irq_is(1'b1);
    reg_rd(OFS_STAT, 8'h0E);
    irq_is(1'b0);
    reg_rd(OFS_DATA, 8'h31);
    reg_rd(OFS_DATA, 8'h32);
    reg_rd(OFS_DATA, 8'h34);
    reg_wr(OFS_MASK, 8'h02);
    line.send(8'hA6);
    repeat (4) @(posedge clk_sys);
    irq_is(1'b1);
    reg_rd(OFS_DATA, 8'hA6);
    reg_rd(OFS_STAT, 8'h0A);
    irq_is(1'b0);
    check(8'(line.frame_errs), 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
